// ### sac_pkg.sv
// Shared constants for the serial adapter mode configuration block
package sac_pkg;

  // Register select codes on the two select pins
  localparam logic [1:0] SAC_RS_DATA      = 2'h0;
  localparam logic [1:0] SAC_RS_STATUS    = 2'h1;
  localparam logic [1:0] SAC_RS_MODE      = 2'h2;
  localparam logic [1:0] SAC_RS_LINE      = 2'h3;

  // Reset values
  localparam logic [7:0] SAC_LINE_RESET   = 8'h00;
  localparam logic [7:0] SAC_MODE_RESET   = 8'h00;
  // Mode bits that survive a programmed reset
  localparam logic [7:0] SAC_MODE_PRG_KEEP = 8'hE0;

  // Line configuration field positions
  localparam int SAC_RATE_LSB   = 0;
  localparam int SAC_RATE_MSB   = 3;
  localparam int SAC_RX_SRC_BIT = 4;
  localparam int SAC_WORD_LSB   = 5;
  localparam int SAC_WORD_MSB   = 6;
  localparam int SAC_STOP_BIT   = 7;

  // Mode command field positions
  localparam int SAC_DTR_BIT    = 0;
  localparam int SAC_RX_IRQ_OFF_BIT = 1;
  localparam int SAC_TXCTL_LSB  = 2;
  localparam int SAC_TXCTL_MSB  = 3;
  localparam int SAC_ECHO_BIT   = 4;
  localparam int SAC_PEN_BIT    = 5;
  localparam int SAC_PTYPE_LSB  = 6;
  localparam int SAC_PTYPE_MSB  = 7;

  // Transmit interrupt control codes
  localparam logic [1:0] SAC_TXCTL_RTS_OFF = 2'h0;
  localparam logic [1:0] SAC_TXCTL_IRQ_ON  = 2'h1;
  localparam logic [1:0] SAC_TXCTL_BREAK   = 2'h3;

  // Parity type codes
  localparam logic [1:0] SAC_PAR_ODD   = 2'h0;
  localparam logic [1:0] SAC_PAR_EVEN  = 2'h1;
  localparam logic [1:0] SAC_PAR_MARK  = 2'h2;
  localparam logic [1:0] SAC_PAR_SPACE = 2'h3;

  // Word length codes
  localparam logic [1:0] SAC_WORD_8 = 2'h0;
  localparam logic [1:0] SAC_WORD_5 = 2'h3;
  localparam logic [3:0] SAC_WORD_BITS_MAX = 4'h8;

  // Stop lengths in half bits
  localparam logic [2:0] SAC_STOP_ONE      = 3'h2;
  localparam logic [2:0] SAC_STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] SAC_STOP_TWO      = 3'h4;

  // Oversampling and echo delay (half of a 16x bit)
  localparam int SAC_OVERSAMPLE   = 16;
  localparam int SAC_ECHO_TICKS   = SAC_OVERSAMPLE / 2;

  // Crystal rising edges per 16x tick for each rate code; code 0 uses every rising edge
  localparam int SAC_DIV_W = 12;
  localparam logic [SAC_DIV_W-1:0] SAC_DIV_TABLE [16] = '{
    12'h001, 12'h900, 12'h600, 12'h418, 12'h358, 12'h300, 12'h180, 12'h0C0,
    12'h060, 12'h040, 12'h030, 12'h020, 12'h018, 12'h010, 12'h00C, 12'h006
  };

endpackage

// ### sac_parity.sv
// Parity generation for the selected word length and type, with checking for odd and even types only
`timescale 1ns/1ps
module sac_parity
  import sac_pkg::*;
(
  input  wire logic [7:0] tx_data,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_parity,
  input  wire logic [1:0] word_code,
  input  wire logic [1:0] parity_type,
  input  wire logic       parity_on,
  output logic            tx_parity_bit,
  output logic            rx_parity_err
);

  function automatic logic [7:0] word_mask(input logic [1:0] code);
    word_mask = 8'hFF >> code;
  endfunction

  wire logic [7:0] mask    = word_mask(word_code);
  wire logic       tx_xor  = ^(tx_data & mask);
  wire logic       rx_xor  = ^(rx_data & mask);
  wire logic       check_on = parity_on && !parity_type[1];

  wire logic odd_bit_tx  = ~tx_xor;
  wire logic even_bit_tx = tx_xor;

  always_comb begin
    unique case (parity_type)
      SAC_PAR_ODD:  tx_parity_bit = odd_bit_tx;
      SAC_PAR_EVEN: tx_parity_bit = even_bit_tx;
      SAC_PAR_MARK: tx_parity_bit = 1'b1;
      SAC_PAR_SPACE: tx_parity_bit = 1'b0;
    endcase
  end

  assign rx_parity_err = check_on &&
                         ((parity_type == SAC_PAR_ODD) ? !(rx_xor ^ rx_parity) : (rx_xor ^ rx_parity));

endmodule

// ### sac_top.sv
// Mode and line configuration registers of the serial adapter with clock and pin control
`timescale 1ns/1ps
module sac_top
  import sac_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CS0,
  input  wire logic       CS1_N,
  input  wire logic [1:0] RS,
  input  wire logic       RW,
  input  wire logic       ACCESS_STB,
  input  wire logic [7:0] D_IN,
  output logic      [7:0] D_OUT,
  output logic            D_OE_N,
  input  wire logic [7:0] STATUS_IN,
  input  wire logic [7:0] RXDATA_IN,
  output logic      [7:0] WR_DATA,
  output logic            TXDATA_WR,
  output logic            RXDATA_RD,
  output logic            STATUS_RD,
  output logic            PROG_RESET,
  input  wire logic       XTLI,
  input  wire logic       RX_CLK_IN,
  output logic            RX_CLK_OUT,
  output logic            RX_CLK_OE_N,
  input  wire logic       RXD,
  input  wire logic       TX_SERIAL,
  output logic            TXD,
  output logic            RTS_N,
  output logic            DTR_N,
  output logic            TX_TICK16,
  output logic            RX_TICK16,
  output logic      [3:0] WORD_BITS,
  output logic      [2:0] STOP_HALVES,
  output logic            PARITY_ENABLE,
  output logic            PARITY_CHECK_EN,
  input  wire logic [7:0] TX_DATA_IN,
  output logic            TX_PARITY_BIT,
  input  wire logic [7:0] RX_DATA_IN,
  input  wire logic       RX_PARITY_IN,
  output logic            RX_PARITY_ERR,
  output logic            TX_IRQ_EN,
  output logic            RX_IRQ_EN,
  output logic            MODEM_IRQ_EN,
  output logic            ECHO_MODE,
  output logic            BREAK_ACTIVE
);

  localparam int NSYNC = 3;

  logic [7:0]           line_reg;
  logic [7:0]           line_next;
  logic [7:0]           mode_reg;
  logic [7:0]           mode_next;
  logic [7:0]           dout_reg;
  logic                 doe_n_reg;
  logic [7:0]           wr_data_reg;
  logic                 txwr_reg;
  logic                 rxrd_reg;
  logic                 strd_reg;
  logic                 prst_reg;
  logic [NSYNC-1:0]     sync1_reg;
  logic [NSYNC-1:0]     sync2_reg;
  logic [NSYNC-1:0]     prev_reg;
  logic [SAC_DIV_W-1:0] div_cnt_reg;
  logic [SAC_DIV_W-1:0] div_cnt_next;
  logic                 tx_tick_reg;
  logic                 rx_clk_out_reg;
  logic [SAC_ECHO_TICKS-1:0] echo_reg;
  logic                 txd_reg;

  // Bus decode
  wire logic       selected   = CS0 && !CS1_N && ACCESS_STB;
  wire logic       wr_access  = selected && !RW;
  wire logic       rd_access  = selected && RW;
  wire logic       wr_mode    = wr_access && (RS == SAC_RS_MODE);
  wire logic       wr_line    = wr_access && (RS == SAC_RS_LINE);
  wire logic       wr_prog    = wr_access && (RS == SAC_RS_STATUS);

  // Field decode
  wire logic [3:0] rate_code  = line_reg[SAC_RATE_MSB:SAC_RATE_LSB];
  wire logic       rx_src     = line_reg[SAC_RX_SRC_BIT];
  wire logic [1:0] word_code  = line_reg[SAC_WORD_MSB:SAC_WORD_LSB];
  wire logic       stop_sel   = line_reg[SAC_STOP_BIT];
  wire logic       dtr        = mode_reg[SAC_DTR_BIT];
  wire logic       rx_irq_off = mode_reg[SAC_RX_IRQ_OFF_BIT];
  wire logic [1:0] tx_ctl     = mode_reg[SAC_TXCTL_MSB:SAC_TXCTL_LSB];
  wire logic       echo       = mode_reg[SAC_ECHO_BIT];
  wire logic       pen        = mode_reg[SAC_PEN_BIT];
  wire logic [1:0] ptype      = mode_reg[SAC_PTYPE_MSB:SAC_PTYPE_LSB];

  // Register writes
  always_comb begin
    line_next = line_reg;
    mode_next = mode_reg;
    if (wr_line) begin
      line_next = D_IN;
    end
    if (wr_mode) begin
      mode_next = D_IN;
    // Programmed reset clears low mode bits
    end else if (wr_prog) begin
      mode_next = mode_reg & SAC_MODE_PRG_KEEP;
    end
  end

  wire logic [7:0] rd_mux = (RS == SAC_RS_MODE)   ? mode_reg :
                            (RS == SAC_RS_LINE)   ? line_reg :
                            (RS == SAC_RS_STATUS) ? STATUS_IN : RXDATA_IN;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_reg <= SAC_LINE_RESET;
      mode_reg <= SAC_MODE_RESET;
    end else begin
      line_reg <= line_next;
      mode_reg <= mode_next;
    end
  end

  // Bus answers and strobes to the neighbouring blocks
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dout_reg    <= 8'h00;
      doe_n_reg   <= 1'b1;
      wr_data_reg <= 8'h00;
      txwr_reg    <= 1'b0;
      rxrd_reg    <= 1'b0;
      strd_reg    <= 1'b0;
      prst_reg    <= 1'b0;
    end else begin
      if (rd_access) begin
        dout_reg <= rd_mux;
      end
      if (wr_access) begin
        wr_data_reg <= D_IN;
      end
      doe_n_reg <= !rd_access;
      txwr_reg  <= wr_access && (RS == SAC_RS_DATA);
      rxrd_reg  <= rd_access && (RS == SAC_RS_DATA);
      strd_reg  <= rd_access && (RS == SAC_RS_STATUS);
      prst_reg  <= wr_prog;
    end
  end

  // Pin synchronisers: crystal, receive clock, receive data
  wire logic [NSYNC-1:0] pins_in = {RXD, RX_CLK_IN, XTLI};
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire logic xtl_s     = sync2_reg[0];
  wire logic rxd_s     = sync2_reg[2];
  wire logic xtl_rise  = sync2_reg[0] && !prev_reg[0];
  wire logic rx_clk_rise = sync2_reg[1] && !prev_reg[1];

  wire logic [SAC_DIV_W-1:0] div_val  = SAC_DIV_TABLE[rate_code];
  wire logic [SAC_DIV_W-1:0] div_last = div_val - 12'h001;
  wire logic [SAC_DIV_W-1:0] div_half = div_val >> 1;
  // Code zero takes every rising crystal edge
  wire logic ext_rate  = (rate_code == 4'h0);
  wire logic wrap      = ext_rate || (div_cnt_reg >= div_last);

  always_comb begin
    div_cnt_next = div_cnt_reg;
    if (xtl_rise) begin
      div_cnt_next = wrap ? '0 : div_cnt_reg + 12'h001;
    end
  end

  // Counter compare uses >= so a rate change never overruns the wrap
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_reg <= '0;
      tx_tick_reg <= 1'b0;
      rx_clk_out_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      tx_tick_reg <= xtl_rise && wrap;
      rx_clk_out_reg <= ext_rate ? xtl_s : (div_cnt_reg < div_half);
    end
  end

  wire logic rx_tick = rx_src ? tx_tick_reg : rx_clk_rise;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      echo_reg <= '1;
    end else if (rx_tick) begin
      echo_reg <= {echo_reg[SAC_ECHO_TICKS-2:0], rxd_s};
    end
  end

  wire logic brk = (tx_ctl == SAC_TXCTL_BREAK);

  wire logic txd_next = brk  ? 1'b0 :
                        echo ? echo_reg[SAC_ECHO_TICKS-1] : TX_SERIAL;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txd_reg <= 1'b1;
    end else begin
      txd_reg <= txd_next;
    end
  end

  wire logic [2:0] stop_halves = !stop_sel ? SAC_STOP_ONE :
                                 ((word_code == SAC_WORD_5) && !pen) ? SAC_STOP_ONE_HALF :
                                 ((word_code == SAC_WORD_8) && pen)  ? SAC_STOP_ONE : SAC_STOP_TWO;

  sac_parity u_parity (
    .tx_data       (TX_DATA_IN),
    .rx_data       (RX_DATA_IN),
    .rx_parity     (RX_PARITY_IN),
    .word_code     (word_code),
    .parity_type   (ptype),
    .parity_on     (pen),
    .tx_parity_bit (TX_PARITY_BIT),
    .rx_parity_err (RX_PARITY_ERR)
  );

  // Bus outputs
  assign D_OUT      = dout_reg;
  assign D_OE_N     = doe_n_reg;
  assign WR_DATA    = wr_data_reg;
  assign TXDATA_WR  = txwr_reg;
  assign RXDATA_RD  = rxrd_reg;
  assign STATUS_RD  = strd_reg;
  assign PROG_RESET = prst_reg;

  // Clocks
  assign TX_TICK16 = tx_tick_reg;
  assign RX_TICK16 = rx_tick;
  // Drive receive clock pin on internal rate
  assign RX_CLK_OUT  = rx_clk_out_reg;
  assign RX_CLK_OE_N = !rx_src;

  assign TXD = txd_reg;

  assign RTS_N = !echo && (tx_ctl == SAC_TXCTL_RTS_OFF);
  assign DTR_N = !dtr;

  assign WORD_BITS       = SAC_WORD_BITS_MAX - {2'b00, word_code};
  assign STOP_HALVES     = stop_halves;
  assign PARITY_ENABLE   = pen;
  assign PARITY_CHECK_EN = pen && !ptype[1];

  // Transmit interrupt only on code one
  assign TX_IRQ_EN    = dtr && (tx_ctl == SAC_TXCTL_IRQ_ON);
  assign RX_IRQ_EN    = dtr && !rx_irq_off;
  assign MODEM_IRQ_EN = dtr && !rx_irq_off;
  assign ECHO_MODE    = echo;
  assign BREAK_ACTIVE = brk;

endmodule

// ### sac_assertions.sv
// Port-level checks for the serial adapter mode configuration block
`timescale 1ns/1ps
module sac_assertions
  import sac_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CS0,
  input wire logic       CS1_N,
  input wire logic [1:0] RS,
  input wire logic       RW,
  input wire logic       ACCESS_STB,
  input wire logic [7:0] D_IN,
  input wire logic [7:0] D_OUT,
  input wire logic       D_OE_N,
  input wire logic       PROG_RESET,
  input wire logic       RX_CLK_OE_N,
  input wire logic       TXD,
  input wire logic       RTS_N,
  input wire logic       DTR_N,
  input wire logic [3:0] WORD_BITS,
  input wire logic [2:0] STOP_HALVES,
  input wire logic       PARITY_CHECK_EN,
  input wire logic       TX_IRQ_EN,
  input wire logic       RX_IRQ_EN,
  input wire logic       BREAK_ACTIVE
);
  logic [7:0] mode_sh_reg;
  logic [7:0] line_sh_reg;
  logic       rd;
  logic       wr;
  logic [2:0] stop_exp;
  assign rd = CS0 && !CS1_N && ACCESS_STB && RW;
  assign wr = CS0 && !CS1_N && ACCESS_STB && !RW;
  assign stop_exp = !line_sh_reg[7] ? 3'h2 : (line_sh_reg[6:5] == 2'h3 && !mode_sh_reg[5]) ? 3'h3 :
                    (line_sh_reg[6:5] == 2'h0 && mode_sh_reg[5]) ? 3'h2 : 3'h4;
  // Shadows rebuilt from bus traffic alone, independent of the design
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_sh_reg <= 8'h00;
      line_sh_reg <= 8'h00;
    end else if (wr && RS == SAC_RS_MODE) begin
      mode_sh_reg <= D_IN;
    end else if (wr && RS == SAC_RS_LINE) begin
      line_sh_reg <= D_IN;
    end else if (wr && RS == SAC_RS_STATUS) begin
      mode_sh_reg <= mode_sh_reg & 8'hE0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd_mode; rd && RS == SAC_RS_MODE; endsequence
  sequence s_rd_line; rd && RS == SAC_RS_LINE; endsequence
  sequence s_prg; wr && RS == SAC_RS_STATUS; endsequence
  read_mode_a: assert property (s_rd_mode |=> D_OUT == $past(mode_sh_reg))
    else $error("mode readback wrong");
  read_line_a: assert property (s_rd_line |=> D_OUT == $past(line_sh_reg))
    else $error("line readback wrong");
  oe_window_a: assert property (D_OE_N == !$past(rd))
    else $error("data enable window wrong");
  prg_pulse_a: assert property (s_prg |=> PROG_RESET ##1 !PROG_RESET)
    else $error("programmed reset pulse wrong");
  word_len_a: assert property (WORD_BITS == 4'h8 - {2'h0, line_sh_reg[6:5]})
    else $error("word length wrong");
  stop_len_a: assert property (STOP_HALVES == stop_exp)
    else $error("stop length wrong");
  rts_level_a: assert property (RTS_N == (mode_sh_reg[3:2] == 2'h0 && !mode_sh_reg[4]))
    else $error("request to send level wrong");
  break_space_a: assert property (BREAK_ACTIVE |=> !TXD)
    else $error("break not at space");
  dtr_level_a: assert property (DTR_N == !mode_sh_reg[0])
    else $error("terminal ready level wrong");
  rx_irq_a: assert property (RX_IRQ_EN == (mode_sh_reg[0] && !mode_sh_reg[1]))
    else $error("receive interrupt gate wrong");
  tx_irq_a: assert property (TX_IRQ_EN == (mode_sh_reg[0] && mode_sh_reg[3:2] == 2'h1))
    else $error("transmit interrupt gate wrong");
  par_check_a: assert property (PARITY_CHECK_EN == (mode_sh_reg[5] && !mode_sh_reg[7]))
    else $error("parity check enable wrong");
  clk_dir_a: assert property (RX_CLK_OE_N == !line_sh_reg[4])
    else $error("receive clock direction wrong");
endmodule
bind sac_top sac_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .CS0(CS0), .CS1_N(CS1_N), .RS(RS), .RW(RW),
  .ACCESS_STB(ACCESS_STB), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_N(D_OE_N), .PROG_RESET(PROG_RESET),
  .RX_CLK_OE_N(RX_CLK_OE_N), .TXD(TXD), .RTS_N(RTS_N), .DTR_N(DTR_N), .WORD_BITS(WORD_BITS),
  .STOP_HALVES(STOP_HALVES), .PARITY_CHECK_EN(PARITY_CHECK_EN), .TX_IRQ_EN(TX_IRQ_EN),
  .RX_IRQ_EN(RX_IRQ_EN), .BREAK_ACTIVE(BREAK_ACTIVE));

// ### sac_modem.sv
// Modem model driving the external receive clock and receive data
`timescale 1ns/1ps
module sac_modem (
  input  wire logic en,
  input  wire logic rxd_val,
  output logic      rx_clk,
  output logic      rxd
);
  // Clock stands still between frames; odd offset keeps it off the bus clock
  initial begin
    rx_clk = 1'b0;
    #3;
    forever #80 rx_clk = en ? !rx_clk : 1'b0;
  end
  // Idle line rests at mark
  assign rxd = en ? rxd_val : 1'b1;
endmodule

// ### sac_top_tb.sv
// Self-checking bench for the mode configuration block
`timescale 1ns/1ps
module sac_top_tb;
  import sac_pkg::*;
  logic       CLK, RST_N, CS0, CS1_N, RW, ACCESS_STB, XTLI, RX_CLK_IN, RXD, TX_SERIAL, RX_PARITY_IN;
  logic [1:0] RS;
  logic [7:0] D_IN, D_OUT, STATUS_IN, RXDATA_IN, WR_DATA, TX_DATA_IN, RX_DATA_IN;
  logic       D_OE_N, TXDATA_WR, RXDATA_RD, STATUS_RD, PROG_RESET, RX_CLK_OUT, RX_CLK_OE_N, TXD, RTS_N, DTR_N;
  logic       TX_TICK16, RX_TICK16, PARITY_ENABLE, PARITY_CHECK_EN, TX_PARITY_BIT, RX_PARITY_ERR;
  logic       TX_IRQ_EN, RX_IRQ_EN, MODEM_IRQ_EN, ECHO_MODE, BREAK_ACTIVE, m_en, m_val;
  logic [3:0] WORD_BITS;
  logic [2:0] STOP_HALVES;
  int         failures, total_checks, cyc, tc, rc, e, oc;
  sac_top u_dut (
    .CLK(CLK), .RST_N(RST_N), .CS0(CS0), .CS1_N(CS1_N), .RS(RS), .RW(RW), .ACCESS_STB(ACCESS_STB),
    .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_N(D_OE_N), .STATUS_IN(STATUS_IN), .RXDATA_IN(RXDATA_IN),
    .WR_DATA(WR_DATA), .TXDATA_WR(TXDATA_WR), .RXDATA_RD(RXDATA_RD), .STATUS_RD(STATUS_RD),
    .PROG_RESET(PROG_RESET), .XTLI(XTLI), .RX_CLK_IN(RX_CLK_IN), .RX_CLK_OUT(RX_CLK_OUT),
    .RX_CLK_OE_N(RX_CLK_OE_N), .RXD(RXD), .TX_SERIAL(TX_SERIAL), .TXD(TXD), .RTS_N(RTS_N), .DTR_N(DTR_N),
    .TX_TICK16(TX_TICK16), .RX_TICK16(RX_TICK16), .WORD_BITS(WORD_BITS), .STOP_HALVES(STOP_HALVES),
    .PARITY_ENABLE(PARITY_ENABLE), .PARITY_CHECK_EN(PARITY_CHECK_EN), .TX_DATA_IN(TX_DATA_IN),
    .TX_PARITY_BIT(TX_PARITY_BIT), .RX_DATA_IN(RX_DATA_IN), .RX_PARITY_IN(RX_PARITY_IN),
    .RX_PARITY_ERR(RX_PARITY_ERR), .TX_IRQ_EN(TX_IRQ_EN), .RX_IRQ_EN(RX_IRQ_EN),
    .MODEM_IRQ_EN(MODEM_IRQ_EN), .ECHO_MODE(ECHO_MODE), .BREAK_ACTIVE(BREAK_ACTIVE));
  sac_modem u_modem (.en(m_en), .rxd_val(m_val), .rx_clk(RX_CLK_IN), .rxd(RXD));
  always #5 CLK = !CLK;
  initial begin
    #7;
    forever #20 XTLI = !XTLI;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic [1:0] rs, input logic rw, input logic [7:0] d);
    @(negedge CLK);
    RS = rs;
    RW = rw;
    D_IN = d;
    ACCESS_STB = 1'b1;
    @(negedge CLK);
    ACCESS_STB = 1'b0;
  endtask
  task automatic rd(input logic [1:0] rs, input logic [7:0] exp, input string nm);
    acc(rs, 1'b1, 8'h00);
    chk(nm, exp, D_OUT);
  endtask
  task automatic ticks();
    logic ro;
    tc = 0;
    rc = 0;
    oc = 0;
    ro = RX_CLK_OUT;
    repeat (400) begin
      @(negedge CLK);
      tc += int'(TX_TICK16);
      rc += int'(RX_TICK16);
      oc += int'(RX_CLK_OUT && !ro);
      ro = RX_CLK_OUT;
    end
  endtask
  initial begin
    {CLK, RST_N, RW, ACCESS_STB, XTLI, RX_PARITY_IN, m_en, m_val} = '0;
    // Transmitter stream idles at mark
    TX_SERIAL = 1'b1;
    {CS0, CS1_N, RS, D_IN, TX_DATA_IN, RX_DATA_IN} = {2'b10, 2'h0, 8'h00, 8'h07, 8'h07};
    {STATUS_IN, RXDATA_IN} = {8'h5A, 8'h3C};
    repeat (20) @(negedge CLK);
    RST_N = 1'b1;
    rd(SAC_RS_MODE, 8'h00, "mode");
    rd(SAC_RS_LINE, 8'h00, "line");
    chk("dtr_n", 8'h01, DTR_N);
    for (int i = 0; i < 4; i++) begin
      acc(SAC_RS_LINE, 1'b0, {1'b1, i[1:0], 5'h00});
      chk("word_bits", 8'h08 - 8'(i), WORD_BITS);
      chk("stop", (i == 3) ? 8'h03 : 8'h04, STOP_HALVES);
      rd(SAC_RS_LINE, {1'b1, i[1:0], 5'h00}, "line");
    end
    acc(SAC_RS_LINE, 1'b0, 8'h80);
    acc(SAC_RS_MODE, 1'b0, 8'h20);
    chk("stop", 8'h02, STOP_HALVES);
    for (int t = 0; t < 4; t++) begin
      acc(SAC_RS_MODE, 1'b0, {4'h0, t[1:0], 2'b01});
      @(negedge CLK);
      chk("rts_n", (t == 0), RTS_N);
      chk("tx_irq", (t == 1), TX_IRQ_EN);
      chk("break", (t == 3), BREAK_ACTIVE);
      chk("txd", (t != 3), TXD);
      chk("rx_irq", 8'h01, RX_IRQ_EN);
      chk("dtr_n", 8'h00, DTR_N);
      chk("modem_irq", 8'h01, MODEM_IRQ_EN);
    end
    acc(SAC_RS_MODE, 1'b0, 8'h03);
    chk("rx_irq", 8'h00, RX_IRQ_EN);
    chk("modem_irq", 8'h00, MODEM_IRQ_EN);
    acc(SAC_RS_MODE, 1'b0, 8'h00);
    chk("rx_irq", 8'h00, RX_IRQ_EN);
    chk("par_err", 8'h00, RX_PARITY_ERR);
    RX_PARITY_IN = 1'b1;
    acc(SAC_RS_LINE, 1'b0, 8'h00);
    for (int p = 0; p < 4; p++) begin
      acc(SAC_RS_MODE, 1'b0, {p[1:0], 6'h20});
      chk("tx_parity", 8'(4'h6 >> p) & 8'h01, TX_PARITY_BIT);
      chk("par_err", (p == 0), RX_PARITY_ERR);
      chk("check_en", (p < 2), PARITY_CHECK_EN);
      chk("par_en", 8'h01, PARITY_ENABLE);
    end
    // Bits above a five-bit word must not count
    TX_DATA_IN = 8'hE7;
    acc(SAC_RS_LINE, 1'b0, 8'h60);
    acc(SAC_RS_MODE, 1'b0, 8'h20);
    chk("tx_parity", 8'h00, TX_PARITY_BIT);
    acc(SAC_RS_MODE, 1'b0, 8'hEF);
    acc(SAC_RS_LINE, 1'b0, 8'h3C);
    acc(SAC_RS_STATUS, 1'b0, 8'hFF);
    rd(SAC_RS_MODE, 8'hE0, "mode");
    rd(SAC_RS_LINE, 8'h3C, "line");
    acc(SAC_RS_DATA, 1'b0, 8'h11);
    chk("wr_data", 8'h11, WR_DATA);
    chk("txdata_wr", 8'h01, TXDATA_WR);
    CS1_N = 1'b1;
    acc(SAC_RS_MODE, 1'b0, 8'h01);
    CS1_N = 1'b0;
    CS0 = 1'b0;
    acc(SAC_RS_MODE, 1'b0, 8'h01);
    CS0 = 1'b1;
    rd(SAC_RS_MODE, 8'hE0, "mode");
    rd(SAC_RS_STATUS, 8'h5A, "status");
    chk("status_rd", 8'h01, STATUS_RD);
    rd(SAC_RS_DATA, 8'h3C, "rx_data");
    chk("rxdata_rd", 8'h01, RXDATA_RD);
    for (int k = 0; k < 3; k++) begin
      acc(SAC_RS_LINE, 1'b0, (k == 0) ? 8'h10 : (k == 1) ? 8'h1E : 8'h1F);
      repeat (30) @(negedge CLK);
      ticks();
      e = (k == 0) ? 100 : (k == 1) ? 8 : 16;
      chk("tx_rate", 8'h01, tc >= e && tc <= e + 1);
      chk("rx_rate", 8'h01, rc == tc);
      chk("rx_clk_out", 8'h01, oc >= e - 1 && oc <= e + 1);
    end
    acc(SAC_RS_LINE, 1'b0, 8'h00);
    acc(SAC_RS_MODE, 1'b0, 8'h10);
    chk("rts_echo", 8'h00, RTS_N);
    chk("echo_mode", 8'h01, ECHO_MODE);
    m_en = 1'b1;
    repeat (320) @(negedge CLK);
    chk("echo_txd", 8'h00, TXD);
    m_val = 1'b1;
    repeat (320) @(negedge CLK);
    chk("echo_txd", 8'h01, TXD);
    m_en = 1'b0;
    complete_run();
  end
endmodule
